// ===== design/dms_defs.svh
`ifndef DMS_DEFS_SVH
`define DMS_DEFS_SVH
`define DMS_IDX_MAIN 8'h20
`define DMS_IDX_STAT 8'h21
`define DMS_IDX_SCR 8'h27
`define DMS_IDX_CTL 8'h28
`define DMS_IDX_AH 8'h29
`define DMS_IDX_AM 8'h2A
`define DMS_IDX_AL 8'h2B
`define DMS_IDX_DH 8'h2C
`define DMS_IDX_DL 8'h2D
`define DMS_IDX_MH 8'h2E
`define DMS_IDX_ML 8'h2F
`define DMS_MAIN_ARM 7
`define DMS_MAIN_BKA 6
`define DMS_CTL_SZE 7
`define DMS_CTL_SZ 6
`define DMS_CTL_TAG 5
`define DMS_CTL_BRK 4
`define DMS_CTL_RW 3
`define DMS_CTL_RWE 2
`define DMS_CTL_NDB 1
`define DMS_CTL_EN 0
`define DMS_CTL_MASK_A 8'hFF
`define DMS_CTL_MASK_B 8'h3D
`define DMS_CTL_MASK_C 8'hFD
`define DMS_VIEW_S1 2'h0
`define DMS_VIEW_S2 2'h1
`define DMS_VIEW_S3 2'h2
`define DMS_VIEW_MFR 2'h3
`define DMS_D_NO 2'h0
`define DMS_D_S1 2'h1
`define DMS_D_S2 2'h2
`define DMS_D_FIN 2'h3
`define DMS_SC3_0 4'h0
`define DMS_SC3_1 4'h1
`define DMS_SC3_2 4'h2
`define DMS_SC3_3 4'h3
`define DMS_SC3_4 4'h4
`define DMS_SC3_5 4'h5
`define DMS_SC3_6 4'h6
`define DMS_SC3_7 4'h7
`define DMS_SC3_A 4'hA
`define DMS_SC3_D 4'hD
`define DMS_SC3_E 4'hE
`define DMS_RESP_OK 2'h0
`define DMS_RESP_ERR 2'h2
`define DMS_RST_BYTE 8'h00
`endif

// ===== design/dms_pkg.sv
`default_nettype none
package dms_pkg;
    typedef enum logic [2:0] {
        DMS_DIS = 3'h0,
        DMS_S1  = 3'h1,
        DMS_S2  = 3'h3,
        DMS_S3  = 3'h2,
        DMS_FIN = 3'h6
    } dms_seq_t;
    typedef struct packed {
        logic        valid;
        logic        rd;
        logic        byte_sz;
        logic [17:0] addr;
        logic [15:0] data;
    } dms_core_t;
    typedef struct packed {
        logic        valid;
        logic [17:0] addr;
    } dms_exec_t;
    typedef struct packed {
        logic            armed;
        logic            bk_allow;
        logic [1:0]      view;
        logic [3:0]      scr1;
        logic [3:0]      scr2;
        logic [3:0]      scr3;
        logic [2:0]      flags;
        logic [2:0]      tag_pend;
        dms_seq_t        seq;
        logic [2:0][7:0] ctl;
        logic [2:0][17:0] cadr;
        logic [15:0]     dcmp;
        logic [15:0]     dmask;
        logic            aw_ok;
        logic            w_ok;
        logic [7:0]      widx;
        logic [7:0]      wdat;
        logic            wen;
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [7:0]      rdat;
        logic [1:0]      rresp;
        logic            bkpt;
        logic            stop;
    } dms_regs_t;
endpackage : dms_pkg
`default_nettype wire

// ===== design/dms_top.sv
// The implementer's own choice: the AXI4-Lite slave port.
`include "dms_defs.svh"
`default_nettype none
module dms_top #(
    parameter int AW = 12
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_ce,
    input  wire dms_pkg::dms_core_t i_bus,
    input  wire dms_pkg::dms_exec_t i_exec,
    input  wire logic [AW-1:0]     i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic                   o_bvalid,
    output logic [1:0]             o_bresp,
    input  wire logic              i_bready,
    input  wire logic [AW-1:0]     i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic                   o_rvalid,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    input  wire logic              i_rready,
    output logic                   o_armed,
    output dms_pkg::dms_seq_t      o_seq,
    output logic [2:0]             o_flags,
    output logic                   o_breakpoint,
    output logic                   o_trace_stop
);
    dms_pkg::dms_regs_t r;
    dms_pkg::dms_regs_t nx;
    logic [2:0] en;
    logic [2:0] raw;
    logic [2:0] hit;
    logic [2:0] m;
    logic [2:0] immediate_break;
    logic [5:0] dest;
    logic [2:0] fin_m;
    logic       wr_go;
    logic       arm_wr;
    logic       ar_take;
    logic [7:0] aidx;
    logic [7:0] rv;

    // per channel destination in state3, packed {ch2, ch1, ch0}
    function automatic logic [5:0] dms_s3_dest(input logic [3:0] code);
        case (code)
            `DMS_SC3_0: return {`DMS_D_NO, `DMS_D_NO, `DMS_D_S1};
            `DMS_SC3_4: return {`DMS_D_NO, `DMS_D_S2, `DMS_D_NO};
            `DMS_SC3_5: return {`DMS_D_NO, `DMS_D_FIN, `DMS_D_NO};
            `DMS_SC3_7: return {`DMS_D_NO, `DMS_D_NO, `DMS_D_FIN};
            `DMS_SC3_1: return {`DMS_D_S2, `DMS_D_FIN, `DMS_D_NO};
            `DMS_SC3_2: return {`DMS_D_NO, `DMS_D_S1, `DMS_D_FIN};
            `DMS_SC3_3: return {`DMS_D_S1, `DMS_D_FIN, `DMS_D_NO};
            `DMS_SC3_6: return {`DMS_D_S2, `DMS_D_NO, `DMS_D_FIN};
            `DMS_SC3_E: return {`DMS_D_FIN, `DMS_D_NO, `DMS_D_S2};
            `DMS_SC3_A: return {`DMS_D_S1, `DMS_D_S1, `DMS_D_FIN};
            `DMS_SC3_D: return {`DMS_D_FIN, `DMS_D_FIN, `DMS_D_S1};
            default: return {`DMS_D_NO, `DMS_D_NO, `DMS_D_NO};
        endcase
    endfunction : dms_s3_dest

    // comparator match logic, same clock as the core bus so no synchroniser
    always_comb
    begin
        for (int c = 0; c < 3; c++)
        begin
            en[c]  = r.ctl[c][`DMS_CTL_EN];
            immediate_break[c] = r.ctl[c][`DMS_CTL_BRK];
            raw[c] = en[c] && i_bus.valid && (i_bus.addr == r.cadr[c]);
            if (!r.ctl[c][`DMS_CTL_TAG])
            begin
                if (r.ctl[c][`DMS_CTL_SZE] && (i_bus.byte_sz != r.ctl[c][`DMS_CTL_SZ]))
                    raw[c] = 1'b0;
                if (r.ctl[c][`DMS_CTL_RWE] && (i_bus.rd != r.ctl[c][`DMS_CTL_RW]))
                    raw[c] = 1'b0;
                if ((c == 0) && (((((i_bus.data ^ r.dcmp) & r.dmask) == 16'h0000)
                    ? 1'b0 : 1'b1) != r.ctl[c][`DMS_CTL_NDB]))
                    raw[c] = 1'b0;
            end
            hit[c] = en[c] && r.tag_pend[c] && i_exec.valid && (i_exec.addr == r.cadr[c]);
            m[c] = r.armed && (r.ctl[c][`DMS_CTL_TAG] ? hit[c] : raw[c]);
        end
    end

    always_comb
    begin
        dest = dms_s3_dest(r.scr3);
        for (int c = 0; c < 3; c++)
            fin_m[c] = m[c] && (dest[2*c +: 2] == `DMS_D_FIN);
    end

    assign wr_go   = r.aw_ok && r.w_ok && !r.bvalid;
    assign arm_wr  = wr_go && r.wen && (r.widx == `DMS_IDX_MAIN) && r.wdat[`DMS_MAIN_ARM];
    assign ar_take = r.arready && i_arvalid;
    assign aidx    = i_araddr[9:2];

    // read mux; the bank view steers both the shared state address and the window
    always_comb
    begin
        rv = `DMS_RST_BYTE;
        case (aidx)
            `DMS_IDX_MAIN: rv = {r.armed, r.bk_allow, 4'h0, r.view};
            `DMS_IDX_STAT: rv = {5'h00, r.seq};
            `DMS_IDX_SCR:
                case (r.view)
                    `DMS_VIEW_S1: rv = {4'h0, r.scr1};
                    `DMS_VIEW_S2: rv = {4'h0, r.scr2};
                    `DMS_VIEW_S3: rv = {4'h0, r.scr3};
                    default: rv = {5'h00, r.flags};
                endcase
            `DMS_IDX_CTL: rv = (r.view == `DMS_VIEW_MFR) ? 8'h00 : r.ctl[r.view];
            `DMS_IDX_AH: rv = (r.view == `DMS_VIEW_MFR) ? 8'h00 : {6'h00, r.cadr[r.view][17:16]};
            `DMS_IDX_AM: rv = (r.view == `DMS_VIEW_MFR) ? 8'h00 : r.cadr[r.view][15:8];
            `DMS_IDX_AL: rv = (r.view == `DMS_VIEW_MFR) ? 8'h00 : r.cadr[r.view][7:0];
            `DMS_IDX_DH: rv = (r.view == `DMS_VIEW_S1) ? r.dcmp[15:8] : 8'h00;
            `DMS_IDX_DL: rv = (r.view == `DMS_VIEW_S1) ? r.dcmp[7:0] : 8'h00;
            `DMS_IDX_MH: rv = (r.view == `DMS_VIEW_S1) ? r.dmask[15:8] : 8'h00;
            `DMS_IDX_ML: rv = (r.view == `DMS_VIEW_S1) ? r.dmask[7:0] : 8'h00;
            default: rv = `DMS_RST_BYTE;
        endcase
    end

    always_comb
    begin
        nx = r;
        nx.bkpt = 1'b0;
        nx.stop = 1'b0;
        // axi write address and data, taken in either order
        if (r.awready && i_awvalid)
        begin
            nx.aw_ok = 1'b1;
            nx.widx = i_awaddr[9:2];
        end
        if (r.wready && i_wvalid)
        begin
            nx.w_ok = 1'b1;
            nx.wdat = i_wdata[7:0];
            nx.wen = i_wstrb[0];
        end
        if (r.bvalid && i_bready)
            nx.bvalid = 1'b0;
        // sequencer
        if (r.armed && |(m & immediate_break))
        begin
            nx.armed = 1'b0;
            nx.seq = dms_pkg::DMS_DIS;
            nx.bkpt = r.bk_allow;
            nx.stop = 1'b1;
        end
        else
        begin
            case (r.seq)
                dms_pkg::DMS_S1: if (|m) nx.seq = dms_pkg::DMS_S2;
                dms_pkg::DMS_S2: if (|m) nx.seq = dms_pkg::DMS_S3;
                dms_pkg::DMS_S3:
                    if (|fin_m)
                        nx.seq = dms_pkg::DMS_FIN;
                    else
                    begin
                        for (int c = 2; c >= 0; c--)
                            if (m[c] && (dest[2*c +: 2] == `DMS_D_S1))
                                nx.seq = dms_pkg::DMS_S1;
                            else if (m[c] && (dest[2*c +: 2] == `DMS_D_S2))
                                nx.seq = dms_pkg::DMS_S2;
                    end
                dms_pkg::DMS_FIN: nx.seq = dms_pkg::DMS_DIS;
                default: nx.seq = dms_pkg::DMS_DIS;
            endcase
            if (nx.seq == dms_pkg::DMS_FIN && r.seq != dms_pkg::DMS_FIN)
            begin
                nx.armed = 1'b0;
                nx.bkpt = r.bk_allow;
                nx.stop = 1'b1;
            end
        end
        for (int c = 0; c < 3; c++)
        begin
            if (hit[c])
                nx.tag_pend[c] = 1'b0;
            if (r.armed && r.ctl[c][`DMS_CTL_TAG] && raw[c])
                nx.tag_pend[c] = 1'b1;
        end
        // register write commits when both halves are in
        if (wr_go)
        begin
            nx.aw_ok = 1'b0;
            nx.w_ok = 1'b0;
            nx.bvalid = 1'b1;
            nx.bresp = ((r.widx == `DMS_IDX_MAIN) || (r.widx == `DMS_IDX_STAT) ||
                       ((r.widx >= `DMS_IDX_SCR) && (r.widx <= `DMS_IDX_ML)))
                       ? `DMS_RESP_OK : `DMS_RESP_ERR;
            if (r.wen && (r.widx == `DMS_IDX_MAIN))
            begin
                nx.view = r.wdat[1:0];
                nx.bk_allow = r.wdat[`DMS_MAIN_BKA];
                nx.armed = r.wdat[`DMS_MAIN_ARM];
                if (r.wdat[`DMS_MAIN_ARM])
                begin
                    nx.flags = 3'h0;
                    nx.tag_pend = 3'h0;
                    nx.seq = dms_pkg::DMS_S1;
                end
                else
                    nx.seq = dms_pkg::DMS_DIS;
            end
            else if (r.wen && !r.armed)
            begin
                case (r.widx)
                    `DMS_IDX_SCR:
                        case (r.view)
                            `DMS_VIEW_S1: nx.scr1 = r.wdat[3:0];
                            `DMS_VIEW_S2: nx.scr2 = r.wdat[3:0];
                            `DMS_VIEW_S3: nx.scr3 = r.wdat[3:0];
                            default: nx.flags = r.flags;
                        endcase
                    `DMS_IDX_CTL:
                        case (r.view)
                            `DMS_VIEW_S1: nx.ctl[0] = r.wdat & `DMS_CTL_MASK_A;
                            `DMS_VIEW_S2: nx.ctl[1] = r.wdat & `DMS_CTL_MASK_B;
                            `DMS_VIEW_S3: nx.ctl[2] = r.wdat & `DMS_CTL_MASK_C;
                            default: nx.ctl = r.ctl;
                        endcase
                    `DMS_IDX_AH:
                        if (r.view != `DMS_VIEW_MFR)
                            nx.cadr[r.view][17:16] = r.wdat[1:0];
                    `DMS_IDX_AM:
                        if (r.view != `DMS_VIEW_MFR)
                            nx.cadr[r.view][15:8] = r.wdat;
                    `DMS_IDX_AL:
                        if (r.view != `DMS_VIEW_MFR)
                            nx.cadr[r.view][7:0] = r.wdat;
                    `DMS_IDX_DH: if (r.view == `DMS_VIEW_S1) nx.dcmp[15:8] = r.wdat;
                    `DMS_IDX_DL: if (r.view == `DMS_VIEW_S1) nx.dcmp[7:0] = r.wdat;
                    `DMS_IDX_MH: if (r.view == `DMS_VIEW_S1) nx.dmask[15:8] = r.wdat;
                    `DMS_IDX_ML: if (r.view == `DMS_VIEW_S1) nx.dmask[7:0] = r.wdat;
                    default: nx.wen = r.wen;
                endcase
            end
        end
        // set after any arm clear so a same-cycle match is never lost
        nx.flags = nx.flags | m;
        nx.awready = !nx.aw_ok && !nx.bvalid;
        nx.wready = !nx.w_ok && !nx.bvalid;
        // reads: one in flight, answer one cycle after the address
        if (r.rvalid && i_rready)
            nx.rvalid = 1'b0;
        if (ar_take)
        begin
            nx.rvalid = 1'b1;
            nx.rdat = rv;
            nx.rresp = ((aidx == `DMS_IDX_MAIN) || (aidx == `DMS_IDX_STAT) ||
                       ((aidx >= `DMS_IDX_SCR) && (aidx <= `DMS_IDX_ML)))
                       ? `DMS_RESP_OK : `DMS_RESP_ERR;
        end
        nx.arready = !nx.rvalid;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            r <= '0;
        end
        else if (i_ce)
        begin
            r <= nx;
        end
    end

    assign o_awready    = r.awready;
    assign o_wready     = r.wready;
    assign o_bvalid     = r.bvalid;
    assign o_bresp      = r.bresp;
    assign o_arready    = r.arready;
    assign o_rvalid     = r.rvalid;
    assign o_rdata      = {24'h000000, r.rdat};
    assign o_rresp      = r.rresp;
    assign o_armed      = r.armed;
    assign o_seq        = r.seq;
    assign o_flags      = r.flags;
    assign o_breakpoint = r.bkpt;
    assign o_trace_stop = r.stop;

    scr3_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && r.armed) |=> $stable(r.scr3))
        else $error("state3 code changed while armed");
    fin_first_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && r.seq == dms_pkg::DMS_S3 && |fin_m && !(|(m & immediate_break)) && !wr_go)
        |=> (r.seq == dms_pkg::DMS_FIN) ##1 (r.seq != dms_pkg::DMS_FIN || !i_ce))
        else $error("final transition not taken first");
    off_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (m & ~en) == 3'h0)
        else $error("disabled channel matched");
    flag_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && |m) |=> ((r.flags & $past(m)) == $past(m)))
        else $error("match flag not set");
    flag_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && !arm_wr) |=> ((r.flags & $past(r.flags)) == $past(r.flags)))
        else $error("match flag cleared without arming");
    brk_end_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && r.armed && |(m & immediate_break))
        |=> (!r.armed && r.seq == dms_pkg::DMS_DIS && r.stop))
        else $error("immediate break did not end session");
    rsv_still_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && r.seq == dms_pkg::DMS_S3 && dest == 6'h00 && !(|(m & immediate_break)) && !wr_go)
        |=> r.seq == dms_pkg::DMS_S3)
        else $error("reserved code moved sequencer");
    none_view_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && ar_take && r.view == `DMS_VIEW_MFR && aidx >= `DMS_IDX_CTL
        && aidx <= `DMS_IDX_ML) |=> (r.rvalid && r.rdat == 8'h00))
        else $error("window not empty at view 11");
    fin_reach_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        r.seq == dms_pkg::DMS_FIN);
    brk_hit_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        r.bkpt);
    tag_fire_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        |(hit & m));
endmodule : dms_top
`default_nettype wire

// ===== tb/dms_core_model.sv
`default_nettype none
module dms_core_model
(
    input  wire logic          i_clk,
    output dms_pkg::dms_core_t o_bus,
    output dms_pkg::dms_exec_t o_exec
);
    timeunit 1ns;
    timeprecision 1ns;
    initial o_bus = '0;
    initial o_exec = '0;
    // idle lines carry the inverse so a stale address can never look current
    task automatic access(input logic [17:0] a, input logic [15:0] d,
                          input logic rd, input logic bs);
        @(posedge i_clk);
        o_bus <= {1'b1, rd, bs, a, d};
        @(posedge i_clk);
        o_bus <= {1'b0, ~rd, ~bs, ~a, ~d};
        @(posedge i_clk);
    endtask : access
    task automatic execute(input logic [17:0] a);
        @(posedge i_clk);
        o_exec <= {1'b1, a};
        @(posedge i_clk);
        o_exec <= {1'b0, ~a};
        @(posedge i_clk);
    endtask : execute
endmodule : dms_core_model
`default_nettype wire

// ===== tb/tb_top.sv
`include "dms_defs.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic               awready, wready, bvalid, arready, rvalid, armed, bkpt, tstop;
    logic [11:0]        awaddr, araddr;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp;
    logic [2:0]         flags, m;
    dms_pkg::dms_seq_t  seq;
    dms_pkg::dms_core_t bus;
    dms_pkg::dms_exec_t exe;
    logic [1:0]         bq[$];
    logic [33:0]        rq[$];
    int                 err_count, compares, v, k, c, p, r, nstop, nbrk;
    integer             seed;
    logic [7:0]         wv[8];
    logic [7:0]         e;
    logic [17:0]        ad[3];
    logic [5:0]         dtab[16] = '{6'h01, 6'h2C, 6'h07, 6'h1C, 6'h08, 6'h0C, 6'h23, 6'h03,
                                     6'h00, 6'h00, 6'h17, 6'h00, 6'h00, 6'h3D, 6'h32, 6'h00};
    logic [7:0]         cc[14] = '{8'h01, 8'h00, 8'hC1, 8'hC1, 8'h81, 8'h81, 8'h0D,
                                   8'h0D, 8'h05, 8'h01, 8'h03, 8'h03, 8'hEF, 8'h11};
    dms_top u_dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_bus(bus), .i_exec(exe),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bvalid(bvalid), .o_bresp(bresp), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rvalid(rvalid), .o_rdata(rdata), .o_rresp(rresp), .i_rready(rready),
        .o_armed(armed), .o_seq(seq), .o_flags(flags),
        .o_breakpoint(bkpt), .o_trace_stop(tstop)
    );
    dms_core_model u_core (.i_clk(clk), .o_bus(bus), .o_exec(exe));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [33:0] ex, input logic [33:0] got);
        compares++;
        if (got !== ex)
        begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask : chk
    always @(posedge clk)
    begin
        if (bvalid === 1'b1 && bready)
            chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
        if (rvalid === 1'b1 && rready)
            chk("read", rq.pop_front(), {rresp, rdata});
        // session-end pulses last one cycle, so count them as they pass
        if (tstop === 1'b1) nstop++;
        if (bkpt === 1'b1) nbrk++;
    end
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] ix, input logic [7:0] d,
                      input logic [1:0] er = `DMS_RESP_OK, input logic [3:0] s = 4'hF);
        int n;
        @(posedge clk);
        bq.push_back(er);
        awaddr <= {2'h0, ix, 2'h0};
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end
        while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        if (n >= 100) err_count++;
    endtask : wr
    task automatic rd(input logic [7:0] ix, input logic [7:0] d,
                      input logic [1:0] er = `DMS_RESP_OK);
        int n;
        @(posedge clk);
        rq.push_back({er, 24'h0, d});
        araddr <= {2'h0, ix, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            n++;
        end
        while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        if (n >= 100) err_count++;
    endtask : rd
    task automatic set_cmp(input int n, input logic [7:0] ctl, input logic [17:0] a);
        wr(`DMS_IDX_MAIN, 8'(n));
        wr(`DMS_IDX_CTL, ctl);
        wr(`DMS_IDX_AH, {6'h0, a[17:16]});
        wr(`DMS_IDX_AM, a[15:8]);
        wr(`DMS_IDX_AL, a[7:0]);
    endtask : set_cmp
    // final beats everything, else the lowest matching channel wins
    function automatic logic [2:0] exp_seq(input logic [3:0] cd, input logic [2:0] mm);
        logic [1:0] d, lo;
        logic       fin;
        lo = 2'h0;
        fin = 1'b0;
        for (int j = 2; j >= 0; j--)
        begin
            d = dtab[cd][2*j +: 2];
            if (mm[j] && d == 2'h3) fin = 1'b1;
            if (mm[j] && d != 2'h3 && d != 2'h0) lo = d;
        end
        if (fin) return dms_pkg::DMS_DIS;
        if (lo == 2'h1) return dms_pkg::DMS_S1;
        if (lo == 2'h2) return dms_pkg::DMS_S2;
        return dms_pkg::DMS_S3;
    endfunction : exp_seq
    initial
    begin
        #(100 * 30000);
        err_count++;
        complete_run();
    end
    initial
    begin
        seed = 82;
        {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        for (v = 0; v < 4; v++)
        begin
            wr(`DMS_IDX_MAIN, 8'(v));
            for (k = 0; k < 8; k++)
            begin
                wv[k] = (k == 0) ? 8'hFF : 8'($random(seed));
                if (k == 1) wv[k] = wv[k] & 8'h03;
                wr(8'h28 + 8'(k), wv[k]);
            end
            for (k = 0; k < 8; k++)
            begin
                e = (v == 3 || (k > 3 && v != 0)) ? 8'h00 : wv[k];
                if (k == 0 && v < 3) e = e & ((v == 1) ? `DMS_CTL_MASK_B : `DMS_CTL_MASK_C);
                if (k == 0 && v == 0) e = `DMS_CTL_MASK_A;
                rd(8'h28 + 8'(k), e);
            end
        end
        $display("window test done");
        wr(`DMS_IDX_MAIN, 8'h02);
        wr(`DMS_IDX_SCR, 8'h05);
        wr(`DMS_IDX_SCR, 8'h0A, `DMS_RESP_OK, 4'h0);
        rd(`DMS_IDX_SCR, 8'h05);
        wr(`DMS_IDX_MAIN, 8'h82);
        wr(`DMS_IDX_SCR, 8'h0A);
        rd(`DMS_IDX_SCR, 8'h05);
        wr(`DMS_IDX_MAIN, 8'h03);
        wr(`DMS_IDX_SCR, 8'h07);
        rd(`DMS_IDX_SCR, 8'h00);
        wr(`DMS_IDX_MAIN, 8'h00);
        rd(`DMS_IDX_SCR, 8'h00);
        wr(8'h30, 8'h01, `DMS_RESP_ERR);
        rd(8'h30, 8'h00, `DMS_RESP_ERR);
        $display("access test done");
        for (p = 0; p < 2; p++)
        begin
            for (k = 0; k < 3; k++)
                ad[k] = (p == 1 && k > 0) ? ad[0] : {2'(k), 16'($random(seed))};
            for (k = 2; k >= 0; k--)
                set_cmp(k, 8'h01, ad[k]);
            wr(`DMS_IDX_MH, 8'h00);
            wr(`DMS_IDX_ML, 8'h00);
            for (c = 0; c < 16; c++)
            begin
                for (k = 0; k < 3 - 2 * p; k++)
                begin
                    m = (p == 1) ? 3'h7 : 3'(1 << k);
                    wr(`DMS_IDX_MAIN, 8'h02);
                    wr(`DMS_IDX_SCR, {4'h0, 4'(c)});
                    wr(`DMS_IDX_MAIN, 8'h83);
                    u_core.access(ad[0], 16'h0, 1'b0, 1'b0);
                    u_core.access(ad[0], 16'h0, 1'b0, 1'b0);
                    u_core.access(ad[k], 16'h0, 1'b0, 1'b0);
                    rd(`DMS_IDX_STAT, {5'h0, exp_seq(4'(c), m)});
                    rd(`DMS_IDX_SCR, {5'h0, m | 3'h1});
                    wr(`DMS_IDX_MAIN, 8'h03);
                    rd(`DMS_IDX_SCR, {5'h0, m | 3'h1});
                end
            end
        end
        $display("sequencer test done");
        set_cmp(1, 8'h00, ad[0]);
        set_cmp(2, 8'h00, ad[0]);
        wr(`DMS_IDX_MAIN, 8'h00);
        wr(`DMS_IDX_DH, 8'h5A);
        wr(`DMS_IDX_DL, 8'hA5);
        wr(`DMS_IDX_MH, 8'hFF);
        wr(`DMS_IDX_ML, 8'hFF);
        for (r = 0; r < 14; r++)
        begin
            e = (r == 13) ? 8'h0 : {5'h0, (r % 2 == 0) ? dms_pkg::DMS_S2 : dms_pkg::DMS_S1};
            wr(`DMS_IDX_MAIN, 8'h00);
            wr(`DMS_IDX_CTL, cc[r]);
            wr(`DMS_IDX_MAIN, (r == 13) ? 8'hC3 : 8'h83);
            c = nstop;
            p = nbrk;
            u_core.access(ad[0], (r == 9 || r == 10 || r == 12) ? 16'h1234 : 16'h5AA5,
                          r == 6, r == 2 || r == 5);
            if (r == 12) u_core.execute(ad[0]);
            rd(`DMS_IDX_STAT, e);
            rd(`DMS_IDX_SCR, {7'h0, e != 8'h01});
            chk("armed", 34'(r != 13), {33'h0, armed});
            chk("stop", 34'(r == 13), 34'(nstop - c));
            chk("brk", 34'(r == 13), 34'(nbrk - p));
        end
        $display("match condition test done");
        repeat (4) @(posedge clk);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
